// ---- flash_pm_regs.sv ----
// Purpose : Power-management register pair of the flash media function:
//           capabilities word and control/status word on config space.
// Assumes : All inputs come from logic on clk_sys_i; global_reset_n_i is a
//           synchronous, already-synchronised chip reset.
// Notes   : rst_i (ordinary bus reset) and the D3hot exit reset leave the
//           control/status word alone; only global reset clears it.
`timescale 1ns/1ps

module flash_pm_regs
  import pm_regs_pkg::*;
(
  // Clock, resets and enable
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic                       global_reset_n_i,
  input  wire logic                       d3hot_exit_rst_i,
  input  wire logic                       ce_i,
  // Configuration access
  input  wire logic                       cfg_rd_i,
  input  wire logic                       cfg_wr_i,
  input  wire logic [pm_regs_pkg::ADDR_W-1:0] cfg_addr_i,
  input  wire logic [1:0]                 cfg_be_i,
  input  wire logic [pm_regs_pkg::DATA_W-1:0] cfg_wdata_i,
  output logic      [pm_regs_pkg::DATA_W-1:0] cfg_rdata_o,
  output logic                            cfg_rvalid_o,
  // Controls from the general control register
  input  wire logic                       cold_wake_support_ctrl_i,
  input  wire logic                       version_select_ctrl_i,
  // Function side
  input  wire logic                       wake_event_i,
  output logic                            wake_req_o,
  output pm_regs_pkg::power_state_e       power_state_field_o
);

  import pm_regs_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  logic               wake_status_flag_q;
  logic               wake_enable_q;
  power_state_e       power_state_q;
  logic [15:0]        rdata_q;
  logic               rvalid_q;
  logic [15:0]        csr_word;
  logic               hit_cap;
  logic               hit_csr;
  logic               wr_csr_lo;
  logic               wr_csr_hi;
  logic               clr_stat;

  pm_cap_if cap_bus ();

  // ==========================================================================
  // Capabilities word
  // ==========================================================================
  // The two control bits come from a neighbouring register; this word only
  // mirrors them, so a configuration write to it has no effect at all
  assign cap_bus.cold_wake_support_ctrl = cold_wake_support_ctrl_i;
  assign cap_bus.version_select_ctrl    = version_select_ctrl_i;

  pm_cap_word u_cap (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .cap       (cap_bus)
  );

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Word-aligned decode; bit 0 of the address selects nothing here because
  // byte lanes come from cfg_be_i
  assign hit_cap   = (cfg_addr_i[7:1] == CAP_OFFSET[7:1]);
  assign hit_csr   = (cfg_addr_i[7:1] == CSR_OFFSET[7:1]);
  assign wr_csr_lo = cfg_wr_i && hit_csr && cfg_be_i[0];
  assign wr_csr_hi = cfg_wr_i && hit_csr && cfg_be_i[1];

  // Software clears the wake status by writing one to bit 15
  assign clr_stat  = wr_csr_hi && cfg_wdata_i[CSR_STAT_BIT];

  // ==========================================================================
  // Control/status word view
  // ==========================================================================
  // Data scale, data select and reserved bits are constant zero
  always_comb
  begin
    csr_word               = CSR_RESET;
    csr_word[CSR_STAT_BIT] = wake_status_flag_q;
    csr_word[CSR_EN_BIT]   = wake_enable_q;
    csr_word[1:0]          = power_state_q;
  end

  // ==========================================================================
  // Wake status flag
  // ==========================================================================
  // Of the resets only global reset clears it; a wake event in the clearing cycle wins so
  // an event is never lost to a racing software clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!global_reset_n_i)
      wake_status_flag_q <= 1'b0;
    else if (ce_i)
    begin
      if (wake_event_i)
        wake_status_flag_q <= 1'b1;
      else if (clr_stat)
        wake_status_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Wake enable
  // ==========================================================================
  // Not touched by rst_i or the D3hot exit reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!global_reset_n_i)
      wake_enable_q <= 1'b0;
    else if (ce_i && wr_csr_hi)
      wake_enable_q <= cfg_wdata_i[CSR_EN_BIT];
  end

  // ==========================================================================
  // Power state
  // ==========================================================================
  // Any code is accepted; acting on the state is the function's job
  always_ff @(posedge clk_sys_i)
  begin
    if (!global_reset_n_i)
      power_state_q <= PS_D0;
    else if (ce_i && wr_csr_lo)
      power_state_q <= power_state_e'(cfg_wdata_i[1:0]);
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Read data is registered, answering one cycle after cfg_rd_i; unmapped
  // offsets read as zero. Ordinary and D3hot exit resets only flush this
  // pipeline, never the control/status word.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || d3hot_exit_rst_i)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rvalid_q <= cfg_rd_i;
      if (cfg_rd_i)
      begin
        if (hit_cap)
          rdata_q <= cap_bus.cap_word;
        else if (hit_csr)
          rdata_q <= csr_word;
        else
          rdata_q <= 16'h0000;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign cfg_rdata_o         = rdata_q;
  assign cfg_rvalid_o        = rvalid_q;
  // Gating by the enable keeps a stale status from waking the system
  assign wake_req_o          = wake_status_flag_q && wake_enable_q;
  assign power_state_field_o = power_state_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  csr_keep_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (d3hot_exit_rst_i && !cfg_wr_i && !wake_event_i) |=> $stable(csr_word))
    else $error("control/status changed on D3hot exit reset");

  wake_set_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (ce_i && wake_event_i) |=> wake_status_flag_q)
    else $error("wake event did not set status");

  wake_clear_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (ce_i && clr_stat && !wake_event_i) |=> !wake_status_flag_q)
    else $error("software clear of wake status lost");

  wake_hold_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    ($rose(wake_status_flag_q)) |-> $past(wake_event_i))
    else $error("wake status set without an event");

  data_fields_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (rvalid_q && $past(hit_csr)) |-> (cfg_rdata_o[14:13] == 2'h0))
    else $error("data scale field not zero");

  data_select_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (rvalid_q && $past(hit_csr)) |-> (cfg_rdata_o[12:9] == 4'h0))
    else $error("data select field not zero");

  wake_gate_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    !wake_enable_q |-> !wake_req_o)
    else $error("wake request while disabled");

  enable_write_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (ce_i && wr_csr_hi) |=> (wake_enable_q == $past(cfg_wdata_i[8])))
    else $error("wake enable did not take written value");

  csr_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (rvalid_q && $past(hit_csr)) |-> (cfg_rdata_o[7:2] == 6'h00))
    else $error("reserved control/status bits not zero");

  state_write_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (ce_i && wr_csr_lo) |=> (power_state_field_o == $past(cfg_wdata_i[1:0])))
    else $error("power state did not take written code");

  bus_reset_keep_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    (rst_i && !cfg_wr_i && !wake_event_i) |=> $stable(csr_word))
    else $error("ordinary reset disturbed control/status");

  global_clear_a: assert property (@(posedge clk_sys_i)
    !global_reset_n_i |=> (!wake_status_flag_q && !wake_enable_q && power_state_q == PS_D0))
    else $error("global reset did not clear control/status");

  reset_value_a: assert property (@(posedge clk_sys_i)
    (!global_reset_n_i && !cold_wake_support_ctrl_i && !version_select_ctrl_i)
      |=> (csr_word == 16'h0000 && (cap_bus.cap_word == 16'h7E02 || $changed(version_select_ctrl_i)
           || $changed(cold_wake_support_ctrl_i))))
    else $error("reset values wrong");

  wake_req_a: assert property (@(posedge clk_sys_i) disable iff (!global_reset_n_i)
    wake_req_o == (wake_status_flag_q && wake_enable_q))
    else $error("wake request not tied to status and enable");

  read_latency_a: assert property (@(posedge clk_sys_i) disable iff (rst_i || d3hot_exit_rst_i)
    (ce_i && cfg_rd_i && hit_cap) |=> (cfg_rvalid_o && cfg_rdata_o == $past(cap_bus.cap_word)))
    else $error("capability read not answered next cycle");

endmodule : flash_pm_regs

// ---- pm_regs_pkg.sv ----
// Purpose : Constants for the power-management capability register pair of the
//           flash media function (capabilities word and control/status word).
// Assumes : Byte offsets in configuration space, 16-bit registers, one clock.
// Notes   : Reset values and field positions live here only.
//
// Behaviour
// - Capability bit 15 follows the cold-wake support control bit.
// - Capability bits 14..11 read 1111b, wake from D3, D2, D1, D0.
// - Capability bit 10 is hardwired one; writes leave it alone.
// - Capability bit 9 is hardwired one; writes leave it alone.
// - Auxiliary current bits 8..6 read 000b without cold wake, else 001b.
// - Capability bit 5 reads zero, no special initialisation needed.
// - Reserved capability bit 4 always reads zero.
// - Capability bit 3 reads zero, wake needs no PCI clock.
// - Version bits 2..0 read 010b, or 011b when version select is set.
// - Control/status word survives the internal D3hot to D0 reset.
// - Wake status bit 15 resets to zero, hardware sets, software clears.
// - Data scale bits 14..13 read 00b.
// - Data select bits 12..9 read 0h.
// - Writable wake enable at bit 8; clear means no wake signalling.
// - Reserved control/status bits 7..2 read zero.
// - Writable power state bits 1..0: 00 D0, 01 D1, 10 D2, 11 D3hot.
// - Wake status, wake enable, power state clear only on global reset.
// - Reset values are 7E02h for capabilities and 0000h for control/status.

package pm_regs_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0]  CAP_OFFSET        = 8'h46;
  localparam logic [7:0]  CSR_OFFSET        = 8'h48;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 16;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] CAP_RESET         = 16'h7E02;
  localparam logic [15:0] CSR_RESET         = 16'h0000;

  // ==========================================================================
  // Capabilities word fields
  // ==========================================================================
  localparam int          CAP_COLD_BIT      = 15;
  localparam int          CAP_WSUP_LSB      = 11;
  localparam logic [3:0]  CAP_WSUP_VAL      = 4'hF;
  localparam int          CAP_D2_BIT        = 10;
  localparam int          CAP_D1_BIT        = 9;
  localparam int          CAP_AUX_LSB       = 6;
  localparam logic [2:0]  CAP_AUX_SELF      = 3'h0;
  localparam logic [2:0]  CAP_AUX_55MA      = 3'h1;
  localparam logic [2:0]  CAP_VER_OLD       = 3'h2;
  localparam logic [2:0]  CAP_VER_NEW       = 3'h3;

  // ==========================================================================
  // Control/status word fields
  // ==========================================================================
  localparam int          CSR_STAT_BIT      = 15;
  localparam int          CSR_EN_BIT        = 8;
  localparam logic [15:0] CSR_RO_ZERO_MASK  = 16'h7EFC;

  // Power state codes
  typedef enum logic [1:0] {
    PS_D0    = 2'h0,
    PS_D1    = 2'h1,
    PS_D2    = 2'h2,
    PS_D3HOT = 2'h3
  } power_state_e;

endpackage : pm_regs_pkg

// ---- pm_cap_if.sv ----
// Purpose : Carries the control bits that shape the capabilities word and the
//           composed word back to the register bank.
// Assumes : Single clock domain, purely combinational contents.
// Notes   : bank drives the controls, comp builds the word.
`timescale 1ns/1ps

interface pm_cap_if;
  logic        cold_wake_support_ctrl;
  logic        version_select_ctrl;
  logic [15:0] cap_word;

  modport bank (output cold_wake_support_ctrl, output version_select_ctrl, input cap_word);
  modport comp (input cold_wake_support_ctrl, input version_select_ctrl, output cap_word);
endinterface : pm_cap_if

// ---- pm_cap_word.sv ----
// Purpose : Builds the read-only power-management capabilities word.
// Assumes : Control bits are stable register outputs of the same clock.
// Notes   : No storage; writes never reach this word.
`timescale 1ns/1ps

module pm_cap_word
  import pm_regs_pkg::*;
(
  // Clock for the embedded checks only
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control in, word out
  pm_cap_if.comp    cap
);

  // ==========================================================================
  // Word composition
  // ==========================================================================
  // Every field is derived; only bits 15, 8..6 and 2..0 can move
  always_comb
  begin
    cap.cap_word                             = '0;
    cap.cap_word[CAP_COLD_BIT]               = cap.cold_wake_support_ctrl;
    cap.cap_word[CAP_WSUP_LSB +: 4]          = CAP_WSUP_VAL;
    cap.cap_word[CAP_D2_BIT]                 = 1'b1;
    cap.cap_word[CAP_D1_BIT]                 = 1'b1;
    cap.cap_word[CAP_AUX_LSB +: 3]           = cap.cold_wake_support_ctrl ?
                                               CAP_AUX_55MA : CAP_AUX_SELF;
    // Bits 5, 4 and 3 stay at the zero default
    cap.cap_word[2:0]                        = cap.version_select_ctrl ?
                                               CAP_VER_NEW : CAP_VER_OLD;
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  cold_mirror_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cap.cap_word[15] == cap.cold_wake_support_ctrl)
    else $error("cold wake bit does not follow its control");
  wake_support_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cap.cap_word[14:11] == 4'hF)
    else $error("wake support field not 1111b");
  state_two_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cap.cap_word[10])
    else $error("State_two_support bit not one");
  state_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cap.cap_word[9])
    else $error("State_one_support bit not one");
  aux_current_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cap.cap_word[8:6] == (cap.cap_word[15] ? 3'h1 : 3'h0))
    else $error("aux current field wrong for cold wake setting");
  init_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !cap.cap_word[5])
    else $error("special init bit set");
  cap_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !cap.cap_word[4])
    else $error("reserved capability bit set");
  wake_clock_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !cap.cap_word[3])
    else $error("wake clock bit set");
  spec_version_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cap.cap_word[2:0] == (cap.version_select_ctrl ? 3'h3 : 3'h2))
    else $error("version field wrong for select bit");

endmodule : pm_cap_word

// ---- cfg_host_model.sv ----
// Purpose : Configuration-space host that issues reads and writes to the
//           power-management register pair.
// Assumes : Strobes are one-cycle pulses, taken at the next rising edge.
// Notes   : Released address and data lines show the inverse of the last
//           value, so stale values are never mistaken for live ones.
`timescale 1ns/1ps

module cfg_host_model
(
  // Clock and answer from the device
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] cfg_rdata_i,
  input  wire logic        cfg_rvalid_i,
  // Request lines
  output logic             cfg_rd_o,
  output logic             cfg_wr_o,
  output logic [7:0]       cfg_addr_o,
  output logic [1:0]       cfg_be_o,
  output logic [15:0]      cfg_wdata_o
);

  // Idle bus at time zero
  initial
  begin
    cfg_rd_o    = 1'b0;
    cfg_wr_o    = 1'b0;
    cfg_addr_o  = 8'h00;
    cfg_be_o    = 2'h0;
    cfg_wdata_o = 16'h0000;
  end

  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  // Software requests a power state by writing its code in lane 0
  task automatic do_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk_sys_i);
    #1;
    cfg_wr_o    = 1'b1;
    cfg_addr_o  = a;
    cfg_be_o    = be;
    cfg_wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    cfg_wr_o    = 1'b0;
    cfg_addr_o  = ~a;
    cfg_be_o    = 2'h0;
    cfg_wdata_o = ~d;
  endtask : do_write

  // Valid stands one cycle, so it is taken right after the accepting edge
  task automatic do_read(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk_sys_i);
    #1;
    cfg_rd_o   = 1'b1;
    cfg_addr_o = a;
    @(posedge clk_sys_i);
    #1;
    cfg_rd_o   = 1'b0;
    cfg_addr_o = ~a;
    ok         = (cfg_rvalid_i === 1'b1);
    d          = cfg_rdata_i;
  endtask : do_read

endmodule : cfg_host_model

// ---- flash_pm_regs_tb.sv ----
// Purpose : Self-checking bench for the power-management register pair.
// Assumes : Inputs change 1 ns after the rising edge; 25 MHz clock.
// Notes   : Expected words are built from field values, never read back.
`timescale 1ns/1ps

module flash_pm_regs_tb;
  import pm_regs_pkg::*;

  logic         clk_sys_i, rst_i, global_reset_n_i, d3hot_exit_rst_i, ce_i;
  logic         cfg_rd_i, cfg_wr_i, cfg_rvalid_o, wake_event_i, wake_req_o;
  logic         cold_wake_support_ctrl_i, version_select_ctrl_i;
  logic [7:0]   cfg_addr_i;
  logic [1:0]   cfg_be_i;
  logic [15:0]  cfg_wdata_i, cfg_rdata_o, rd_val;
  power_state_e power_state_field_o;
  logic         rd_ok;
  int           n_fail = 0;
  int           tests_run = 0;
  int           i;

  // 40 ns clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  flash_pm_regs DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .global_reset_n_i(global_reset_n_i),
    .d3hot_exit_rst_i(d3hot_exit_rst_i), .ce_i(ce_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .cold_wake_support_ctrl_i(cold_wake_support_ctrl_i),
    .version_select_ctrl_i(version_select_ctrl_i), .wake_event_i(wake_event_i),
    .wake_req_o(wake_req_o), .power_state_field_o(power_state_field_o));

  cfg_host_model host (.clk_sys_i(clk_sys_i), .cfg_rdata_i(cfg_rdata_o),
    .cfg_rvalid_i(cfg_rvalid_o), .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i),
    .cfg_addr_o(cfg_addr_i), .cfg_be_o(cfg_be_i), .cfg_wdata_o(cfg_wdata_i));

  // ==========================================================================
  // Compare and helper tasks
  // ==========================================================================
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // A read must answer with valid exactly one cycle later
  task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
    host.do_read(a, rd_val, rd_ok);
    check_bit(rd_ok, 1'b1);
    check_word(rd_val, exp);
  endtask : read_check

  task automatic next_edge();
    @(posedge clk_sys_i);
    #1;
  endtask : next_edge

  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    rst_i = 1'b1;
    global_reset_n_i = 1'b0;
    d3hot_exit_rst_i = 1'b0;
    ce_i = 1'b1;
    cold_wake_support_ctrl_i = 1'b0;
    version_select_ctrl_i = 1'b0;
    wake_event_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    global_reset_n_i = 1'b1;
    read_check(CAP_OFFSET, 16'h7E02);
    read_check(CSR_OFFSET, 16'h0000);
    check_bit(wake_req_o, 1'b0);
    // Every combination of the two capability controls
    for (i = 0; i < 4; i++)
    begin
      cold_wake_support_ctrl_i = i[0];
      version_select_ctrl_i = i[1];
      read_check(8'h47, {i[0], 4'hF, 2'h3, (i[0] ? 3'h1 : 3'h0), 3'h0, (i[1] ? 3'h3 : 3'h2)});
    end
    cold_wake_support_ctrl_i = 1'b0;
    version_select_ctrl_i = 1'b0;
    host.do_write(CAP_OFFSET, 2'h3, 16'h0000);
    read_check(CAP_OFFSET, 16'h7E02);
    // All ones: only enable and state stick, status stays clear
    host.do_write(CSR_OFFSET, 2'h3, 16'hFFFF);
    read_check(CSR_OFFSET, 16'h0103);
    for (i = 0; i < 4; i++)
    begin
      host.do_write(CSR_OFFSET, 2'h1, {14'h0, i[1:0]});
      read_check(CSR_OFFSET, {7'h0, 1'b1, 6'h0, i[1:0]});
      check_word({14'h0, power_state_field_o}, {14'h0, i[1:0]});
    end
    // Wake event while enabled raises the request
    next_edge();
    wake_event_i = 1'b1;
    next_edge();
    wake_event_i = 1'b0;
    check_bit(wake_req_o, 1'b1);
    read_check(CSR_OFFSET, 16'h8103);
    // Bus reset and D3hot exit reset leave the word alone
    next_edge();
    rst_i = 1'b1;
    next_edge();
    rst_i = 1'b0;
    read_check(CSR_OFFSET, 16'h8103);
    d3hot_exit_rst_i = 1'b1;
    next_edge();
    d3hot_exit_rst_i = 1'b0;
    read_check(CSR_OFFSET, 16'h8103);
    // Frozen clock enable ignores a write
    ce_i = 1'b0;
    host.do_write(CSR_OFFSET, 2'h3, 16'h8000);
    ce_i = 1'b1;
    read_check(CSR_OFFSET, 16'h8103);
    // Lane 1 write clears status and enable together
    host.do_write(CSR_OFFSET, 2'h2, 16'h8000);
    check_bit(wake_req_o, 1'b0);
    read_check(CSR_OFFSET, 16'h0003);
    // Status still latches with enable clear, but no request
    wake_event_i = 1'b1;
    next_edge();
    wake_event_i = 1'b0;
    check_bit(wake_req_o, 1'b0);
    read_check(CSR_OFFSET, 16'h8003);
    read_check(8'h50, 16'h0000);
    // Global reset is the only reset that clears the word
    global_reset_n_i = 1'b0;
    next_edge();
    global_reset_n_i = 1'b1;
    read_check(CSR_OFFSET, 16'h0000);
    check_word({14'h0, power_state_field_o}, 16'h0000);
    stop_test();
  end

  // Watchdog: the sequence needs well under 300 cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    stop_test();
  end

endmodule : flash_pm_regs_tb
